// ===== src/eecc_pkg.sv
// constants, types and field layout of the eeprom command controller
package eecc_pkg;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int FRAME_W = 3 + ADDR_W + DATA_W;
  localparam int NBIT_W  = 5;
  localparam int REG_AW  = 12;

  // register offsets
  localparam logic [REG_AW-1:0] OFF_CMD     = 12'h1B4;
  localparam logic [REG_AW-1:0] OFF_DATA    = 12'h1B8;
  localparam logic [REG_AW-1:0] OFF_CFG     = 12'h1C0;
  localparam logic [REG_AW-1:0] OFF_IRQ_STS = 12'h1C4;
  localparam logic [REG_AW-1:0] OFF_IRQ_MSK = 12'h1C8;

  // command register fields
  localparam int CMD_BUSY  = 31;
  localparam int CMD_OP_HI = 30;
  localparam int CMD_OP_LO = 28;
  localparam int CMD_TMO   = 9;

  // config register fields
  localparam int CFG_TWO_WIRE = 0;
  localparam int CFG_SRST     = 1;
  localparam int CFG_LOADED   = 2;
  localparam int CFG_EW_EN    = 3;

  // interrupt status / mask bits
  localparam int IRQ_W    = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TMO  = 1;
  localparam int IRQ_LOAD = 2;

  typedef enum logic [2:0] {
    OP_READ, OP_ERASE_WRITE_DISABLE, OP_ERASE_WRITE_ENABLE, OP_WRITE, OP_WRITE_ALL_LOCATIONS, OP_ERASE, OP_ERASE_ALL_LOCATIONS, OP_RELOAD
  } eecc_op_t;

  // three-wire serial opcodes and sub-codes in the top address bits
  localparam logic [1:0] SER_RD   = 2'h2;
  localparam logic [1:0] SER_WR   = 2'h1;
  localparam logic [1:0] SER_ER   = 2'h3;
  localparam logic [1:0] SER_EXT  = 2'h0;
  localparam logic [1:0] SUB_ERASE_WRITE_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL_LOCATIONS = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL_LOCATIONS = 2'h2;
  localparam logic [1:0] SUB_ERASE_WRITE_ENABLE = 2'h3;

  localparam logic [DATA_W-1:0] CFG_SIG      = 8'hA5;
  localparam logic [ADDR_W-1:0] LD_SIG_ADDR  = 8'h00;
  localparam logic [ADDR_W-1:0] LD_CFG_ADDR  = 8'h01;
  localparam logic [NBIT_W-1:0] NBITS_SHORT  = NBIT_W'(3 + ADDR_W);
  localparam logic [NBIT_W-1:0] NBITS_LONG   = NBIT_W'(FRAME_W);

  // timing
  localparam int CLK_KHZ     = 40000;
  localparam int TIMEOUT_MS  = 30;
  localparam int TIMEOUT_CYC = CLK_KHZ * TIMEOUT_MS;
  localparam int CLK_DIV     = 20;
  // clocks before a reselected ready line is trusted
  localparam int MISO_SETTLE = 6;
endpackage

// ===== src/eecc_eng_if.sv
// request / answer link between command controller and serial engine
`timescale 1ns/10ps
interface eecc_eng_if;
  logic                       go;
  logic                       abort;
  logic [eecc_pkg::FRAME_W-1:0] frame;
  logic [eecc_pkg::NBIT_W-1:0]  nbits;
  logic                       wait_rdy;
  logic                       done;
  logic                       timed_out;
  logic [eecc_pkg::DATA_W-1:0]  rx;
  modport ctl (output go, abort, frame, nbits, wait_rdy, input done, timed_out, rx);
  modport eng (input go, abort, frame, nbits, wait_rdy, output done, timed_out, rx);
endinterface

// ===== src/eecc_serial_engine.sv
// three-wire serial shifter with ready polling and response timeout
`timescale 1ns/10ps
module eecc_serial_engine #(
  parameter int CLK_DIV     = eecc_pkg::CLK_DIV,
  parameter int TIMEOUT_CYC = eecc_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // controller side
  eecc_eng_if.eng   eng,
  // eeprom pins
  output logic      ee_cs,
  output logic      ee_sclk,
  output logic      ee_mosi,
  input  wire logic ee_miso
);
  localparam int DW = $clog2(CLK_DIV);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int FW = eecc_pkg::FRAME_W;

  // a half bit must outlast the pin synchroniser
  if (CLK_DIV <= eecc_pkg::MISO_SETTLE) $error("CLK_DIV too small");
  if (TIMEOUT_CYC <= eecc_pkg::MISO_SETTLE) $error("TIMEOUT_CYC too small");

  typedef enum logic [1:0] {E_IDLE, E_SHIFT, E_GAP, E_WAIT} eecc_est_t;

  eecc_est_t                 st_r, st_nxt;
  logic [DW-1:0]             div_r, div_nxt;
  logic [FW-1:0]             sh_r, sh_nxt;
  logic [eecc_pkg::NBIT_W-1:0] cnt_r, cnt_nxt;
  logic [TW-1:0]             tcnt_r, tcnt_nxt;
  logic [7:0]                rx_r, rx_nxt;
  logic [2:0]                sync_r;
  logic                      din_r, din_nxt;
  logic                      ph_r, ph_nxt, wt_r, wt_nxt, done_r, done_nxt, tmo_r, tmo_nxt;
  logic                      cs_r, cs_nxt, sclk_r, sclk_nxt, mosi_r, mosi_nxt;
  logic                      tick;

  assign tick          = (div_r == '0);
  assign eng.done      = done_r;
  assign eng.timed_out = tmo_r;
  assign eng.rx        = rx_r;
  assign ee_cs         = cs_r;
  assign ee_sclk       = sclk_r;
  assign ee_mosi       = mosi_r;

  always_comb begin
    st_nxt = st_r;
    div_nxt = (div_r == DW'(CLK_DIV - 1)) ? '0 : div_r + 1'b1;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    tcnt_nxt = tcnt_r;
    rx_nxt = rx_r;
    din_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : din_r;
    ph_nxt = ph_r;
    wt_nxt = wt_r;
    done_nxt = 1'b0;
    tmo_nxt = tmo_r;
    cs_nxt = cs_r;
    sclk_nxt = sclk_r;
    mosi_nxt = mosi_r;
    unique case (st_r)
      E_IDLE: if (eng.go) begin
        st_nxt = E_SHIFT;
        sh_nxt = eng.frame;
        cnt_nxt = eng.nbits;
        wt_nxt = eng.wait_rdy;
        ph_nxt = 1'b0;
        cs_nxt = 1'b1;
        tmo_nxt = 1'b0;
      end
      E_SHIFT: if (tick) begin
        if (!ph_r) begin
          sclk_nxt = 1'b0;
          mosi_nxt = sh_r[FW-1];
          ph_nxt = 1'b1;
        end else begin
          sclk_nxt = 1'b1;
          rx_nxt = {rx_r[6:0], din_r};
          sh_nxt = {sh_r[FW-2:0], 1'b0};
          ph_nxt = 1'b0;
          cnt_nxt = cnt_r - 1'b1;
          if (cnt_r == 1) st_nxt = E_GAP;
        end
      end
      E_GAP: if (tick) begin
        sclk_nxt = 1'b0;
        mosi_nxt = 1'b0;
        cs_nxt = 1'b0;
        tcnt_nxt = '0;
        st_nxt = wt_r ? E_WAIT : E_IDLE;
        done_nxt = !wt_r;
      end
      E_WAIT: begin
        cs_nxt = 1'b1;
        tcnt_nxt = tcnt_r + 1'b1;
        // stale pin level from the frame must not read as ready
        if (din_r && cs_r && tcnt_r >= TW'(eecc_pkg::MISO_SETTLE)) begin
          st_nxt = E_IDLE;
          cs_nxt = 1'b0;
          done_nxt = 1'b1;
        end else if (tcnt_r == TW'(TIMEOUT_CYC - 1)) begin
          st_nxt = E_IDLE;
          cs_nxt = 1'b0;
          done_nxt = 1'b1;
          tmo_nxt = 1'b1;
        end
      end
    endcase
    if (eng.abort) begin
      st_nxt = E_IDLE;
      cs_nxt = 1'b0;
      sclk_nxt = 1'b0;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= E_IDLE;
      div_r <= '0;
      sh_r <= '0;
      cnt_r <= '0;
      tcnt_r <= '0;
      rx_r <= '0;
      sync_r <= '0;
      din_r <= 1'b0;
      ph_r <= 1'b0;
      wt_r <= 1'b0;
      done_r <= 1'b0;
      tmo_r <= 1'b0;
      cs_r <= 1'b0;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      tcnt_r <= tcnt_nxt;
      rx_r <= rx_nxt;
      sync_r <= {sync_r[1:0], ee_miso};
      din_r <= din_nxt;
      ph_r <= ph_nxt;
      wt_r <= wt_nxt;
      done_r <= done_nxt;
      tmo_r <= tmo_nxt;
      cs_r <= cs_nxt;
      sclk_r <= sclk_nxt;
      mosi_r <= mosi_nxt;
    end
  end

  property p_wait_bound;
    @(posedge clk) disable iff (!resetn) st_r == E_WAIT |-> tcnt_r < TW'(TIMEOUT_CYC);
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("ready wait overran");
endmodule // eecc_serial_engine

// ===== src/eecc_cmd_ctrl.sv
// eeprom command register, loader sequence and interrupt logic
`timescale 1ns/10ps
module eecc_cmd_ctrl #(
  parameter int CLK_DIV     = eecc_pkg::CLK_DIV,
  parameter int TIMEOUT_CYC = eecc_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // register port
  input  wire logic [eecc_pkg::REG_AW-1:0] addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [31:0]                 rdata,
  // interrupt
  output logic                             irq,
  // eeprom pins
  output logic                             ee_cs,
  output logic                             ee_sclk,
  output logic                             ee_mosi,
  input  wire logic                        ee_miso
);
  localparam int AW = eecc_pkg::ADDR_W;
  localparam int DW = eecc_pkg::DATA_W;
  localparam int FW = eecc_pkg::FRAME_W;

  if (AW > eecc_pkg::CMD_TMO) $error("address field overlaps timeout bit");

  typedef enum logic [2:0] {S_RST, S_LD_SIG, S_LD_CFG, S_IDLE, S_OP} eecc_st_t;

  eecc_eng_if eng_if ();

  eecc_serial_engine #(
    .CLK_DIV     (CLK_DIV),
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_engine (
    .clk     (clk),
    .resetn  (resetn),
    .eng     (eng_if),
    .ee_cs   (ee_cs),
    .ee_sclk (ee_sclk),
    .ee_mosi (ee_mosi),
    .ee_miso (ee_miso)
  );

  eecc_st_t             st_r, st_nxt;
  eecc_pkg::eecc_op_t   op_r, op_nxt;
  logic [AW-1:0]        addr_r, addr_nxt;
  logic [DW-1:0]        data_r, data_nxt;
  logic [DW-1:0]        cfg_byte_r, cfg_byte_nxt;
  logic                 tmo_r, tmo_nxt;
  logic                 two_wire_r, two_wire_nxt;
  logic                 ew_en_r, ew_en_nxt;
  logic                 loaded_r, loaded_nxt;
  logic [eecc_pkg::IRQ_W-1:0] sts_r, sts_nxt, msk_r, msk_nxt, ev;
  logic                 irq_r, irq_nxt;
  logic [31:0]          rdata_r, rdata_nxt;
  logic                 go_r, go_nxt, abort_r, abort_nxt, wait_r, wait_nxt;
  logic [FW-1:0]        frame_r, frame_nxt;
  logic [eecc_pkg::NBIT_W-1:0] nbits_r, nbits_nxt;
  logic                 busy;
  logic                 wr_cmd, start, unsup, ew_blocked;
  eecc_pkg::eecc_op_t   wop;

  assign busy           = (st_r != S_IDLE);
  assign eng_if.go      = go_r;
  assign eng_if.abort   = abort_r;
  assign eng_if.frame   = frame_r;
  assign eng_if.nbits   = nbits_r;
  assign eng_if.wait_rdy = wait_r;
  assign rdata          = rdata_r;
  assign irq            = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // op decode

  function automatic logic [FW-1:0] mk_frame(eecc_pkg::eecc_op_t op,
                                             logic [AW-1:0] a, logic [DW-1:0] d);
    logic [1:0]    opc;
    logic [AW-1:0] fa;
    logic [DW-1:0] fd;
    opc = eecc_pkg::SER_EXT;
    fa  = {eecc_pkg::SUB_ERASE_WRITE_DISABLE, (AW-2)'(0)};
    fd  = '0;
    unique case (op)
      eecc_pkg::OP_READ, eecc_pkg::OP_RELOAD: begin
        opc = eecc_pkg::SER_RD;
        fa = a;
      end
      eecc_pkg::OP_ERASE_WRITE_DISABLE: fa = {eecc_pkg::SUB_ERASE_WRITE_DISABLE, (AW-2)'(0)};
      eecc_pkg::OP_ERASE_WRITE_ENABLE: fa = {eecc_pkg::SUB_ERASE_WRITE_ENABLE, (AW-2)'(0)};
      eecc_pkg::OP_WRITE: begin
        opc = eecc_pkg::SER_WR;
        fa = a;
        fd = d;
      end
      eecc_pkg::OP_WRITE_ALL_LOCATIONS: begin
        fa = {eecc_pkg::SUB_WRITE_ALL_LOCATIONS, (AW-2)'(0)};
        fd = d;
      end
      eecc_pkg::OP_ERASE: begin
        opc = eecc_pkg::SER_ER;
        fa = a;
      end
      eecc_pkg::OP_ERASE_ALL_LOCATIONS: fa = {eecc_pkg::SUB_ERASE_ALL_LOCATIONS, (AW-2)'(0)};
    endcase
    return {1'b1, opc, fa, fd};
  endfunction

  function automatic logic is_prog(eecc_pkg::eecc_op_t op);
    return op inside {eecc_pkg::OP_WRITE, eecc_pkg::OP_WRITE_ALL_LOCATIONS,
                      eecc_pkg::OP_ERASE, eecc_pkg::OP_ERASE_ALL_LOCATIONS};
  endfunction

  function automatic logic [eecc_pkg::NBIT_W-1:0] op_nbits(eecc_pkg::eecc_op_t op);
    return (op inside {eecc_pkg::OP_READ, eecc_pkg::OP_RELOAD, eecc_pkg::OP_WRITE,
                       eecc_pkg::OP_WRITE_ALL_LOCATIONS}) ? eecc_pkg::NBITS_LONG : eecc_pkg::NBITS_SHORT;
  endfunction

  assign wr_cmd     = wr && (addr == eecc_pkg::OFF_CMD);
  assign wop        = eecc_pkg::eecc_op_t'(wdata[eecc_pkg::CMD_OP_HI:eecc_pkg::CMD_OP_LO]);
  assign start      = wr_cmd && !busy && wdata[eecc_pkg::CMD_BUSY];
  assign unsup      = two_wire_r && (wop inside {eecc_pkg::OP_ERASE_WRITE_DISABLE, eecc_pkg::OP_ERASE_WRITE_ENABLE,
                      eecc_pkg::OP_WRITE_ALL_LOCATIONS, eecc_pkg::OP_ERASE, eecc_pkg::OP_ERASE_ALL_LOCATIONS});
  assign ew_blocked = !two_wire_r && !ew_en_r && is_prog(wop);

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    cfg_byte_nxt = cfg_byte_r;
    tmo_nxt = tmo_r;
    two_wire_nxt = two_wire_r;
    ew_en_nxt = ew_en_r;
    loaded_nxt = loaded_r;
    msk_nxt = msk_r;
    ev = '0;
    go_nxt = 1'b0;
    abort_nxt = 1'b0;
    frame_nxt = frame_r;
    nbits_nxt = nbits_r;
    wait_nxt = wait_r;
    rdata_nxt = '0;

    // register writes; command and data frozen while busy
    if (wr_cmd && !busy) begin
      op_nxt = wop;
      addr_nxt = wdata[AW-1:0];
    end
    if (wr_cmd && wdata[eecc_pkg::CMD_TMO]) tmo_nxt = 1'b0;
    if (wr && addr == eecc_pkg::OFF_DATA && !busy) data_nxt = wdata[DW-1:0];
    if (wr && addr == eecc_pkg::OFF_CFG) two_wire_nxt = wdata[eecc_pkg::CFG_TWO_WIRE];
    if (wr && addr == eecc_pkg::OFF_IRQ_MSK) msk_nxt = wdata[eecc_pkg::IRQ_W-1:0];

    unique case (st_r)
      S_RST: begin
        st_nxt = S_LD_SIG;
        go_nxt = 1'b1;
        frame_nxt = mk_frame(eecc_pkg::OP_READ, eecc_pkg::LD_SIG_ADDR, '0);
        nbits_nxt = eecc_pkg::NBITS_LONG;
        wait_nxt = 1'b0;
      end
      S_LD_SIG: if (eng_if.done) begin
        if (eng_if.rx == eecc_pkg::CFG_SIG) begin
          st_nxt = S_LD_CFG;
          go_nxt = 1'b1;
          frame_nxt = mk_frame(eecc_pkg::OP_READ, eecc_pkg::LD_CFG_ADDR, '0);
        end else begin
          st_nxt = S_IDLE;
          tmo_nxt = 1'b1;
          ev[eecc_pkg::IRQ_TMO] = 1'b1;
        end
      end
      S_LD_CFG: if (eng_if.done) begin
        st_nxt = S_IDLE;
        cfg_byte_nxt = eng_if.rx;
        loaded_nxt = 1'b1;
        ev[eecc_pkg::IRQ_LOAD] = 1'b1;
      end
      S_IDLE: if (start) begin
        if (unsup || ew_blocked) begin
          tmo_nxt = 1'b1;
          ev[eecc_pkg::IRQ_TMO] = 1'b1;
        end else if (wop == eecc_pkg::OP_RELOAD) begin
          st_nxt = S_RST;
          loaded_nxt = 1'b0;
        end else begin
          st_nxt = S_OP;
          go_nxt = 1'b1;
          frame_nxt = mk_frame(wop, wdata[AW-1:0], data_r);
          nbits_nxt = op_nbits(wop);
          wait_nxt = is_prog(wop);
        end
      end
      S_OP: if (eng_if.done) begin
        st_nxt = S_IDLE;
        if (eng_if.timed_out) begin
          tmo_nxt = 1'b1;
          ev[eecc_pkg::IRQ_TMO] = 1'b1;
        end else begin
          ev[eecc_pkg::IRQ_DONE] = 1'b1;
          if (op_r == eecc_pkg::OP_READ) data_nxt = eng_if.rx;
          if (op_r == eecc_pkg::OP_ERASE_WRITE_ENABLE) ew_en_nxt = 1'b1;
          if (op_r == eecc_pkg::OP_ERASE_WRITE_DISABLE) ew_en_nxt = 1'b0;
        end
      end
    endcase

    // soft reset restarts the loader and holds busy
    if (wr && addr == eecc_pkg::OFF_CFG && wdata[eecc_pkg::CFG_SRST]) begin
      st_nxt = S_RST;
      abort_nxt = 1'b1;
      go_nxt = 1'b0;
      op_nxt = eecc_pkg::OP_READ;
      addr_nxt = '0;
      tmo_nxt = 1'b0;
      ew_en_nxt = 1'b0;
      loaded_nxt = 1'b0;
    end

    // sticky status, write one to clear, set wins
    sts_nxt = sts_r;
    if (wr && addr == eecc_pkg::OFF_IRQ_STS) sts_nxt = sts_r & ~wdata[eecc_pkg::IRQ_W-1:0];
    sts_nxt = sts_nxt | ev;
    irq_nxt = |(sts_nxt & msk_nxt);

    if (rd) begin
      unique case (addr)
        eecc_pkg::OFF_CMD: begin
          rdata_nxt[eecc_pkg::CMD_BUSY] = busy;
          rdata_nxt[eecc_pkg::CMD_OP_HI:eecc_pkg::CMD_OP_LO] = op_r;
          rdata_nxt[eecc_pkg::CMD_TMO] = tmo_r;
          rdata_nxt[AW-1:0] = addr_r;
        end
        eecc_pkg::OFF_DATA: rdata_nxt[DW-1:0] = data_r;
        eecc_pkg::OFF_CFG: begin
          rdata_nxt[eecc_pkg::CFG_TWO_WIRE] = two_wire_r;
          rdata_nxt[eecc_pkg::CFG_LOADED] = loaded_r;
          rdata_nxt[eecc_pkg::CFG_EW_EN] = ew_en_r;
          rdata_nxt[15:8] = cfg_byte_r;
        end
        eecc_pkg::OFF_IRQ_STS: rdata_nxt[eecc_pkg::IRQ_W-1:0] = sts_r;
        eecc_pkg::OFF_IRQ_MSK: rdata_nxt[eecc_pkg::IRQ_W-1:0] = msk_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= S_RST;
      op_r <= eecc_pkg::OP_READ;
      addr_r <= '0;
      data_r <= '0;
      cfg_byte_r <= '0;
      tmo_r <= 1'b0;
      two_wire_r <= 1'b0;
      ew_en_r <= 1'b0;
      loaded_r <= 1'b0;
      sts_r <= '0;
      msk_r <= '0;
      irq_r <= 1'b0;
      rdata_r <= '0;
      go_r <= 1'b0;
      abort_r <= 1'b0;
      frame_r <= '0;
      nbits_r <= '0;
      wait_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      cfg_byte_r <= cfg_byte_nxt;
      tmo_r <= tmo_nxt;
      two_wire_r <= two_wire_nxt;
      ew_en_r <= ew_en_nxt;
      loaded_r <= loaded_nxt;
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      go_r <= go_nxt;
      abort_r <= abort_nxt;
      frame_r <= frame_nxt;
      nbits_r <= nbits_nxt;
      wait_r <= wait_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_start;
    start && !unsup && !ew_blocked |=> busy ##1 busy;
  endproperty
  a_start: assert property (p_start) else $error("start did not raise busy");

  property p_busy_hold;
    st_r == S_OP && !eng_if.done && !abort_r |=> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_read_data;
    st_r == S_OP && op_r == eecc_pkg::OP_READ && eng_if.done && !eng_if.timed_out
      |=> !busy && data_r == $past(eng_if.rx);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not loaded");

  property p_tmo_idle;
    st_r == S_OP && eng_if.done && eng_if.timed_out && !abort_r |=> !busy && tmo_r;
  endproperty
  a_tmo_idle: assert property (p_tmo_idle) else $error("timeout did not end op");

  property p_srst_busy;
    wr && addr == eecc_pkg::OFF_CFG && wdata[eecc_pkg::CFG_SRST] |=> busy [*3];
  endproperty
  a_srst_busy: assert property (p_srst_busy) else $error("soft reset left busy low");

  property p_no_start;
    wr_cmd && !busy && !wdata[eecc_pkg::CMD_BUSY] |=> !busy;
  endproperty
  a_no_start: assert property (p_no_start) else $error("op ran without busy");

  property p_unsup;
    start && unsup |=> !busy && tmo_r && sts_r[eecc_pkg::IRQ_TMO];
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported op not refused");

  property p_ew_block;
    start && ew_blocked |=> !busy && tmo_r && !go_r;
  endproperty
  a_ew_block: assert property (p_ew_block) else $error("blocked write ran");

  property p_blank;
    st_r == S_LD_SIG && eng_if.done && eng_if.rx != eecc_pkg::CFG_SIG && !abort_r
      |=> st_r == S_IDLE && !loaded_r;
  endproperty
  a_blank: assert property (p_blank) else $error("blank device accepted");

  property p_zero_busy;
    wr_cmd && busy && !wdata[eecc_pkg::CMD_BUSY] && !eng_if.done |=> busy && $stable(op_r);
  endproperty
  a_zero_busy: assert property (p_zero_busy) else $error("zero write disturbed op");

  c_read: cover property (st_r == S_OP && op_r == eecc_pkg::OP_READ && eng_if.done);
  c_prog_tmo: cover property (st_r == S_OP && eng_if.done && eng_if.timed_out);
  c_loaded: cover property (st_r == S_LD_CFG && eng_if.done);
  c_irq: cover property ($rose(irq_r));
endmodule // eecc_cmd_ctrl

// ===== tb/eecc_ee_model.sv
// behavioural three-wire serial eeprom
`timescale 1ns/10ps
module eecc_ee_model #(
  parameter int BUSY_CYC = 30
) (
  // clock
  input  wire logic clk,
  // pins
  input  wire logic cs,
  input  wire logic sclk,
  input  wire logic mosi,
  output logic      miso,
  // test control
  input  wire logic present
);
  logic [7:0]  mem [256];
  logic [18:0] sh;
  logic [7:0]  a;
  logic [1:0]  op;
  logic        prog = 0;
  logic        dout = 0;
  // set when a program cycle is cut short by the controller
  logic        early = 0;
  int          n = 0;
  int          bc = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    mem[0] = 8'hA5;
    mem[1] = 8'h3C;
  end
  always @(posedge sclk) if (cs) begin
    sh <= {sh[17:0], mosi};
    n <= n + 1;
    if (n == 10) begin
      op <= sh[8:7];
      a <= {sh[6:0], mosi};
    end
  end
  // read data bits lead the sampling edge by half a bit
  always @(negedge sclk) if (cs && n >= 11 && n <= 18 && op == 2'h2) dout <= mem[a][18-n];
  always @(negedge cs) begin
    if (n == 19 && op == 2'h1) mem[a] <= sh[7:0];
    if (prog) begin
      prog <= 1'b0;
      if (present && bc < BUSY_CYC) early <= 1'b1;
    end else if (n >= 11) begin
      prog <= op != 2'h2 && !(op == 2'h0 && (a[7:6] == 2'h0 || a[7:6] == 2'h3));
    end
    n <= 0;
  end
  always @(posedge clk) bc <= (cs && prog) ? bc + 1 : 0;
  // ready after a program cycle, low when absent or deselected
  assign miso = present && cs && (prog ? bc >= BUSY_CYC : dout);
endmodule // eecc_ee_model

// ===== tb/eecc_cmd_ctrl_tb.sv
// self-checking bench for the eeprom command controller
`timescale 1ns/10ps
module eecc_cmd_ctrl_tb;
  localparam logic [11:0] CMD = eecc_pkg::OFF_CMD;
  localparam logic [11:0] DAT = eecc_pkg::OFF_DATA;
  localparam logic [11:0] CFG = eecc_pkg::OFF_CFG;
  localparam logic [11:0] STS = eecc_pkg::OFF_IRQ_STS;
  localparam logic [11:0] MSK = eecc_pkg::OFF_IRQ_MSK;
  logic        clk = 0;
  logic        resetn = 0;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0;
  logic        wr = 0;
  logic        rd = 0;
  logic [31:0] rdata;
  logic        irq;
  logic        cs;
  logic        sclk;
  logic        mosi;
  logic        miso;
  logic        present = 1;
  logic [31:0] v;
  int          fails = 0;
  int          compares = 0;
  always #12.5 clk = ~clk;
  eecc_cmd_ctrl #(.TIMEOUT_CYC(200)) u_dut (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .ee_cs(cs), .ee_sclk(sclk),
    .ee_mosi(mosi), .ee_miso(miso));
  eecc_ee_model u_ee (.clk(clk), .cs(cs), .sclk(sclk), .mosi(mosi), .miso(miso),
    .present(present));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cf(input logic [31:0] m, input logic [31:0] e);
    chk(v & m, e);
  endtask
  task automatic bw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // poll busy only, no command change meanwhile
  task automatic idle();
    int k;
    k = 0;
    br(CMD);
    while (v[31] === 1'b1 && k < 3000) begin
      br(CMD);
      k++;
    end
    cf(32'h8000_0000, 32'h0);
  endtask
  ////////////////////////////////////////
  task automatic t_boot();
    br(CMD);
    cf(32'hF000_0000, 32'h8000_0000);
    idle();
    br(STS);
    cf(32'h4, 32'h4);
    br(CFG);
    cf(32'hFF0C, 32'h3C04);
  endtask
  task automatic t_read();
    u_ee.mem[5] = 8'h5A;
    bw(STS, 32'h7);
    bw(MSK, 32'h1);
    bw(CMD, 32'h8000_0005);
    br(CMD);
    cf(32'h8000_0000, 32'h8000_0000);
    idle();
    br(DAT);
    cf(32'hFF, 32'h5A);
    chk(irq, 1'b1);
    bw(MSK, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    bw(STS, 32'h1);
    br(STS);
    cf(32'h1, 32'h0);
  endtask
  task automatic t_nostart();
    bw(CMD, 32'h3000_0007);
    repeat (5) @(posedge clk);
    chk(cs, 1'b0);
    br(CMD);
    cf(32'h8000_0200, 32'h0);
  endtask
  task automatic t_write();
    bw(CMD, 32'hB000_0009);
    br(CMD);
    cf(32'h8000_0200, 32'h200);
    br(STS);
    cf(32'h2, 32'h2);
    bw(CMD, 32'h200);
    bw(CMD, 32'hA000_0000);
    idle();
    br(CFG);
    cf(32'h8, 32'h8);
    bw(DAT, 32'h77);
    bw(CMD, 32'hB000_0009);
    bw(CMD, 32'h0000_0001);
    br(CMD);
    cf(32'hF000_00FF, 32'hB000_0009);
    idle();
    chk(u_ee.mem[9], 32'h77);
    bw(CMD, 32'h8000_0009);
    idle();
    br(DAT);
    cf(32'hFF, 32'h77);
    present <= 1'b0;
    bw(CMD, 32'hB000_0003);
    br(CMD);
    cf(32'h8000_0200, 32'h8000_0000);
    idle();
    cf(32'h200, 32'h200);
    present <= 1'b1;
    bw(CMD, 32'h9000_0200);
    idle();
    br(CFG);
    cf(32'h8, 32'h0);
  endtask
  task automatic t_modes();
    logic [2:0] ops [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    logic [2:0] pgm [3] = '{3'h4, 3'h5, 3'h6};
    bw(CFG, 32'h1);
    foreach (ops[i]) begin
      bw(CMD, {1'b1, ops[i], 28'h0});
      br(CMD);
      cf(32'h8000_0200, 32'h200);
      chk(cs, 1'b0);
      bw(CMD, 32'h200);
    end
    bw(CFG, 32'h0);
    // program kinds in three-wire mode with erase/write enabled
    bw(CMD, 32'hA000_0000);
    idle();
    foreach (pgm[i]) begin
      bw(CMD, {1'b1, pgm[i], 28'h9});
      br(CMD);
      cf(32'h8000_0200, 32'h8000_0000);
      idle();
      cf(32'h200, 32'h0);
    end
    chk(u_ee.early, 1'b0);
  endtask
  task automatic t_reload();
    u_ee.mem[0] = 8'h00;
    bw(CMD, 32'hF000_0000);
    idle();
    cf(32'h200, 32'h200);
    u_ee.mem[0] = 8'hA5;
    bw(CMD, 32'h200);
    bw(CFG, 32'h2);
    br(CMD);
    cf(32'h8000_0000, 32'h8000_0000);
    idle();
    br(CFG);
    cf(32'hFF04, 32'h3C04);
  endtask
  task automatic test_done();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_boot();
    t_read();
    t_nostart();
    t_write();
    t_modes();
    t_reload();
    test_done();
  end
  initial begin
    #(25 * 80000);
    fails++;
    test_done();
  end
endmodule // eecc_cmd_ctrl_tb
